/* include/usb_core_pkg.sv */
package usb_core_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] FUNC_ADDR_OFS = 8'h00;
   localparam logic [7:0] POWER_OFS = 8'h04;
   localparam logic [7:0] TX_FLAGS_OFS = 8'h08;
   localparam logic [7:0] RX_FLAGS_OFS = 8'h0C;
   localparam logic [7:0] COMMON_OFS = 8'h10;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
   // ==========================================
   // Power control fields
   localparam int ISO_SOF_SYNC_BIT = 7;
   localparam int SOFT_ATTACH_BIT = 6;
   localparam int HS_ALLOW_BIT = 5;
   localparam int HS_ACTIVE_BIT = 4;
   localparam int BUS_RESET_BIT = 3;
   localparam int RESUME_BIT = 2;
   localparam int SUSPEND_STATE_BIT = 1;
   localparam int SUSPEND_OUT_EN_BIT = 0;
   // ==========================================
   // Common flag fields
   localparam int CMN_SUSPEND_BIT = 0;
   localparam int CMN_RESUME_BIT = 1;
   localparam int CMN_RESET_BIT = 2;
   localparam int CMN_SOF_BIT = 3;
   // ==========================================
   // Interrupt status and mask fields
   localparam int IRQ_TX_BIT = 0;
   localparam int IRQ_RX_BIT = 1;
   localparam int IRQ_SUSPEND_BIT = 2;
   localparam int IRQ_RESUME_BIT = 3;
   localparam int IRQ_RESET_BIT = 4;
   localparam int IRQ_SOF_BIT = 5;
   // ==========================================
   // Reset values
   localparam logic [6:0] FUNC_ADDR_RESET = 7'h00;
   localparam logic [7:0] POWER_RESET = 8'h20;
   localparam logic [5:0] IRQ_MASK_RESET = 6'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

/* src/line_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module line_sync #(
   parameter int W = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // ==========================================
   // Two-stage synchroniser
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t q, n;
   always_comb begin
      n.s1 = d_i;
      n.s2 = q.s1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
   assign q_o = q.s2;
endmodule
`default_nettype wire

/* src/iso_sof_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module iso_sof_gate (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sync_en_i,
   input wire logic [3:0] iso_ep_i,
   input wire logic [3:0] loaded_i,
   input wire logic [3:0] sent_i,
   input wire logic [3:0] in_hit_i,
   input wire logic sof_i,
   output logic [3:0] send_ok_o,
   output logic zlp_o
);
   // ==========================================
   // Per-endpoint hold until start of frame
   typedef struct packed {
      logic [3:0] wait_sof;
      logic [3:0] armed;
      logic zlp;
   } gate_t;
   gate_t q, n;
   logic [3:0] wait_n, armed_n, zlp_n;
   genvar e;
   generate
      for (e = 0; e < 4; e++) begin : g_ep
         logic held;
         assign held = sync_en_i & iso_ep_i[e];
         assign wait_n[e] = (loaded_i[e] & held) | (q.wait_sof[e] & ~sof_i);
         assign armed_n[e] = (q.armed[e] | (q.wait_sof[e] & sof_i) | (loaded_i[e] & ~held)) & ~sent_i[e];
         assign zlp_n[e] = in_hit_i[e] & q.wait_sof[e];
      end
   endgenerate
   always_comb begin
      n.wait_sof = wait_n;
      n.armed = armed_n;
      n.zlp = |zlp_n;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
   assign send_ok_o = q.armed;
   assign zlp_o = q.zlp;
endmodule
`default_nettype wire

/* src/usb_core_ctrl.sv */
// What this block does
// - Peripheral: match token address against stored address
// - Host: stored address is the peripheral target
// - Peripheral iso sync: hold loaded packet until SOF
// - Iso sync: IN before SOF sends zero-length
// - Peripheral: soft attach bit enables line drivers when available
// - High-speed allow bit permits high-speed negotiation
// - Peripheral: set high-speed active after successful negotiation
// - Bus-reset bit shows reset; host may drive
// - Drive resume while suspended and bit set
// - Host: resume detected while suspended sets bit
// - Peripheral suspend-state set, cleared by read/resume
// - Suspend output driven only when enabled
// - Transmit flags read-only, bits 15-5 zero
// - Receive flags read-only, bit 0 zero
// - Reading common flags clears them all
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module usb_core_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic host_mode_i,
   input wire logic soft_attach_avail_i,
   input wire logic tok_valid_i,
   input wire logic [6:0] tok_addr_i,
   input wire logic sof_tok_i,
   input wire logic in_tok_i,
   input wire logic [3:0] in_ep_hit_i,
   input wire logic [3:0] iso_ep_i,
   input wire logic [3:0] tx_packet_loaded_i,
   input wire logic [4:0] tx_done_i,
   input wire logic [3:0] rx_done_i,
   input wire logic hs_neg_ok_i,
   input wire logic bus_reset_line_i,
   input wire logic suspend_line_i,
   input wire logic resume_line_i,
   output logic addr_match_o,
   output logic [6:0] target_addr_o,
   output logic line_drive_en_o,
   output logic high_speed_allow_o,
   output logic high_speed_active_o,
   output logic drive_reset_o,
   output logic drive_resume_o,
   output logic suspend_o,
   output logic suspend_oe_o,
   output logic [3:0] tx_send_ok_o,
   output logic iso_zlp_o,
   output logic irq_o
);
   // ==========================================
   // State
   typedef struct packed {
      // Bus side
      logic ack;
      logic [31:0] dat;
      // Address and power control
      logic [6:0] dev_addr;
      logic iso_sof_sync;
      logic soft_attach;
      logic high_speed_allow;
      logic high_speed_active;
      logic sw_bus_reset;
      logic resume;
      logic suspend_state;
      logic suspend_out_enable;
      logic suspended;
      // Endpoint and event flags
      logic [4:0] tx_flags;
      logic [3:0] rx_flags;
      logic [3:0] common;
      logic [5:0] irq_stat;
      logic [5:0] irq_mask;
      // Registered outputs
      logic irq;
      logic addr_match;
      logic line_drive_en;
      logic drive_reset;
      logic drive_resume;
      logic suspend_out;
      logic suspend_oe;
      // Line edge history
      logic rst_d;
      logic susp_d;
      logic res_d;
   } ctrl_t;
   ctrl_t q, n;

   // ==========================================
   // Line synchronisers
   logic [2:0] lines;
   logic rst_line, susp_line, res_line;
   line_sync #(.W(3)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({resume_line_i, suspend_line_i, bus_reset_line_i}),
      .q_o(lines)
   );
   assign rst_line = lines[0];
   assign susp_line = lines[1];
   assign res_line = lines[2];

   // ==========================================
   // Isochronous SOF gate
   iso_sof_gate u_iso (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sync_en_i(q.iso_sof_sync & ~host_mode_i),
      .iso_ep_i(iso_ep_i),
      .loaded_i(tx_packet_loaded_i),
      .sent_i(tx_done_i[4:1]),
      .in_hit_i(in_ep_hit_i & {4{in_tok_i}}),
      .sof_i(sof_tok_i),
      .send_ok_o(tx_send_ok_o),
      .zlp_o(iso_zlp_o)
   );

   // ==========================================
   // Bus decode
   logic req, wr, rd;
   logic rst_rise, susp_rise, res_rise;
   logic [7:0] wd;
   logic [7:0] power_rd;
   assign req = cyc_i & stb_i & ~q.ack;
   assign wr = req & we_i & sel_i[0];
   assign rd = req & ~we_i;
   assign wd = dat_i[7:0];

   // ==========================================
   // Register access strobes
   logic rd_tx, rd_rx, rd_common;
   logic wr_addr, wr_power, wr_stat, wr_mask;
   assign rd_tx = rd & (adr_i == usb_core_pkg::TX_FLAGS_OFS);
   assign rd_rx = rd & (adr_i == usb_core_pkg::RX_FLAGS_OFS);
   assign rd_common = rd & (adr_i == usb_core_pkg::COMMON_OFS);
   assign wr_addr = wr & (adr_i == usb_core_pkg::FUNC_ADDR_OFS);
   assign wr_power = wr & (adr_i == usb_core_pkg::POWER_OFS);
   assign wr_stat = wr & (adr_i == usb_core_pkg::IRQ_STAT_OFS);
   assign wr_mask = wr & (adr_i == usb_core_pkg::IRQ_MASK_OFS);

   // ==========================================
   // Line edges
   assign rst_rise = rst_line & ~q.rst_d;
   assign susp_rise = susp_line & ~q.susp_d;
   assign res_rise = res_line & ~q.res_d;

   // ==========================================
   // Power register read view
   always_comb begin
      power_rd = 8'h00;
      power_rd[usb_core_pkg::ISO_SOF_SYNC_BIT] = q.iso_sof_sync;
      power_rd[usb_core_pkg::SOFT_ATTACH_BIT] = q.soft_attach;
      power_rd[usb_core_pkg::HS_ALLOW_BIT] = q.high_speed_allow;
      power_rd[usb_core_pkg::HS_ACTIVE_BIT] = q.high_speed_active;
      power_rd[usb_core_pkg::BUS_RESET_BIT] = rst_line | (host_mode_i & q.sw_bus_reset);
      power_rd[usb_core_pkg::RESUME_BIT] = q.resume;
      power_rd[usb_core_pkg::SUSPEND_STATE_BIT] = q.suspend_state;
      power_rd[usb_core_pkg::SUSPEND_OUT_EN_BIT] = q.suspend_out_enable;
   end

   // ==========================================
   // Next state
   always_comb begin
      n = q;
      n.ack = req;
      n.rst_d = rst_line;
      n.susp_d = susp_line;
      n.res_d = res_line;

      // ==========================================
      // Read data
      if (rd) begin
         unique case (adr_i)
            usb_core_pkg::FUNC_ADDR_OFS: begin
               n.dat = {25'h000_0000, q.dev_addr};
            end
            usb_core_pkg::POWER_OFS: begin
               n.dat = {24'h00_0000, power_rd};
            end
            usb_core_pkg::TX_FLAGS_OFS: begin
               n.dat = {27'h000_0000, q.tx_flags};
            end
            usb_core_pkg::RX_FLAGS_OFS: begin
               n.dat = {27'h000_0000, q.rx_flags, 1'b0};
            end
            usb_core_pkg::COMMON_OFS: begin
               n.dat = {28'h000_0000, q.common};
            end
            usb_core_pkg::IRQ_STAT_OFS: begin
               n.dat = {26'h000_0000, q.irq_stat};
            end
            usb_core_pkg::IRQ_MASK_OFS: begin
               n.dat = {26'h000_0000, q.irq_mask};
            end
            default: begin
               n.dat = usb_core_pkg::READ_ZERO;
            end
         endcase
      end

      // ==========================================
      // Read-to-clear flags, set wins
      if (rd_tx) begin
         n.tx_flags = 5'h00;
      end
      if (rd_rx) begin
         n.rx_flags = 4'h0;
      end
      if (rd_common) begin
         n.common = 4'h0;
      end

      // ==========================================
      // Link event flags
      n.tx_flags = n.tx_flags | tx_done_i;
      n.rx_flags = n.rx_flags | rx_done_i;
      n.common[usb_core_pkg::CMN_SUSPEND_BIT] = n.common[usb_core_pkg::CMN_SUSPEND_BIT] | susp_rise;
      n.common[usb_core_pkg::CMN_RESUME_BIT] = n.common[usb_core_pkg::CMN_RESUME_BIT] | (res_rise & q.suspended);
      n.common[usb_core_pkg::CMN_RESET_BIT] = n.common[usb_core_pkg::CMN_RESET_BIT] | rst_rise;
      n.common[usb_core_pkg::CMN_SOF_BIT] = n.common[usb_core_pkg::CMN_SOF_BIT] | sof_tok_i;

      // ==========================================
      // Register writes
      if (wr_addr) begin
         n.dev_addr = wd[6:0];
      end
      if (wr_power) begin
         n.iso_sof_sync = wd[usb_core_pkg::ISO_SOF_SYNC_BIT];
         n.soft_attach = wd[usb_core_pkg::SOFT_ATTACH_BIT];
         n.high_speed_allow = wd[usb_core_pkg::HS_ALLOW_BIT];
         n.resume = wd[usb_core_pkg::RESUME_BIT];
         n.suspend_out_enable = wd[usb_core_pkg::SUSPEND_OUT_EN_BIT];
         if (host_mode_i) begin
            n.sw_bus_reset = wd[usb_core_pkg::BUS_RESET_BIT];
            n.suspend_state = wd[usb_core_pkg::SUSPEND_STATE_BIT];
         end else if (wd[usb_core_pkg::RESUME_BIT]) begin
            n.suspend_state = 1'b0;
         end
      end

      // ==========================================
      // Interrupt registers
      if (wr_mask) begin
         n.irq_mask = wd[5:0];
      end
      if (wr_stat) begin
         n.irq_stat = q.irq_stat & ~wd[5:0];
      end

      // ==========================================
      // Peripheral suspend indication
      if (!host_mode_i && rd_common) begin
         n.suspend_state = 1'b0;
      end
      if (!host_mode_i && susp_rise) begin
         n.suspend_state = 1'b1;
      end

      // ==========================================
      // Suspended tracking for resume signalling
      if ((host_mode_i ? n.suspend_state : susp_rise)) begin
         n.suspended = 1'b1;
      end else if (rst_rise || (q.suspended && q.resume && !n.resume)) begin
         n.suspended = 1'b0;
      end
      if (host_mode_i && q.suspended && res_rise) begin
         n.resume = 1'b1;
      end

      // ==========================================
      // High-speed negotiation result
      if (rst_rise) begin
         n.high_speed_active = 1'b0;
      end else if (hs_neg_ok_i && q.high_speed_allow && !host_mode_i) begin
         n.high_speed_active = 1'b1;
      end

      // ==========================================
      // Interrupt status, set wins over clear
      n.irq_stat[usb_core_pkg::IRQ_TX_BIT] = n.irq_stat[usb_core_pkg::IRQ_TX_BIT] | (|tx_done_i);
      n.irq_stat[usb_core_pkg::IRQ_RX_BIT] = n.irq_stat[usb_core_pkg::IRQ_RX_BIT] | (|rx_done_i);
      n.irq_stat[usb_core_pkg::IRQ_SUSPEND_BIT] = n.irq_stat[usb_core_pkg::IRQ_SUSPEND_BIT] | susp_rise;
      n.irq_stat[usb_core_pkg::IRQ_RESUME_BIT] = n.irq_stat[usb_core_pkg::IRQ_RESUME_BIT] | (res_rise & q.suspended);
      n.irq_stat[usb_core_pkg::IRQ_RESET_BIT] = n.irq_stat[usb_core_pkg::IRQ_RESET_BIT] | rst_rise;
      n.irq_stat[usb_core_pkg::IRQ_SOF_BIT] = n.irq_stat[usb_core_pkg::IRQ_SOF_BIT] | sof_tok_i;
      n.irq = |(n.irq_stat & n.irq_mask);

      // ==========================================
      // Registered line outputs
      n.addr_match = !host_mode_i && tok_valid_i && tok_addr_i == q.dev_addr;
      n.line_drive_en = !host_mode_i && soft_attach_avail_i && n.soft_attach;
      n.drive_reset = host_mode_i && n.sw_bus_reset;
      n.drive_resume = n.resume && n.suspended;
      n.suspend_out = n.suspend_state && n.suspend_out_enable;
      n.suspend_oe = n.suspend_out_enable;
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.dev_addr <= usb_core_pkg::FUNC_ADDR_RESET;
         q.high_speed_allow <= usb_core_pkg::POWER_RESET[usb_core_pkg::HS_ALLOW_BIT];
         q.iso_sof_sync <= usb_core_pkg::POWER_RESET[usb_core_pkg::ISO_SOF_SYNC_BIT];
         q.soft_attach <= usb_core_pkg::POWER_RESET[usb_core_pkg::SOFT_ATTACH_BIT];
         q.high_speed_active <= usb_core_pkg::POWER_RESET[usb_core_pkg::HS_ACTIVE_BIT];
         q.sw_bus_reset <= usb_core_pkg::POWER_RESET[usb_core_pkg::BUS_RESET_BIT];
         q.resume <= usb_core_pkg::POWER_RESET[usb_core_pkg::RESUME_BIT];
         q.suspend_state <= usb_core_pkg::POWER_RESET[usb_core_pkg::SUSPEND_STATE_BIT];
         q.suspend_out_enable <= usb_core_pkg::POWER_RESET[usb_core_pkg::SUSPEND_OUT_EN_BIT];
         q.irq_mask <= usb_core_pkg::IRQ_MASK_RESET;
      end else begin
         q <= n;
      end
   end

   // ==========================================
   // Outputs
   assign dat_o = q.dat;
   assign ack_o = q.ack;

   // ==========================================
   // Link outputs
   assign addr_match_o = q.addr_match;
   assign target_addr_o = q.dev_addr;
   assign line_drive_en_o = q.line_drive_en;
   assign high_speed_allow_o = q.high_speed_allow;
   assign high_speed_active_o = q.high_speed_active;
   assign drive_reset_o = q.drive_reset;
   assign drive_resume_o = q.drive_resume;
   assign suspend_o = q.suspend_out;
   assign suspend_oe_o = q.suspend_oe;
   assign irq_o = q.irq;
endmodule
`default_nettype wire

/* verification/usb_core_ctrl_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module usb_core_ctrl_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic host_mode_i,
   input wire logic soft_attach_avail_i,
   input wire logic tok_valid_i,
   input wire logic [6:0] tok_addr_i,
   input wire logic in_tok_i,
   input wire logic hs_neg_ok_i,
   input wire logic addr_match_o,
   input wire logic [6:0] target_addr_o,
   input wire logic line_drive_en_o,
   input wire logic high_speed_allow_o,
   input wire logic high_speed_active_o,
   input wire logic drive_reset_o,
   input wire logic suspend_o,
   input wire logic suspend_oe_o,
   input wire logic iso_zlp_o
);
   // ========
   // Bus handshake
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_ack_pulse;
      ack_o ##1 !ack_o;
   endsequence
   a_ack_one_pulse: assert property (s_req |=> s_ack_pulse)
      else $error("ack not a single pulse");
   // ========
   // Link side
   a_match_on_hit: assert property (tok_valid_i && !host_mode_i && tok_addr_i == target_addr_o |=> addr_match_o)
      else $error("address match missing");
   a_match_has_cause: assert property (addr_match_o |-> $past(tok_valid_i && !host_mode_i))
      else $error("address match without token");
   a_drive_periph_only: assert property (line_drive_en_o |-> $past(!host_mode_i && soft_attach_avail_i))
      else $error("line drivers on wrongly");
   a_reset_host_only: assert property (drive_reset_o |-> $past(host_mode_i))
      else $error("reset driven outside host");
   a_suspend_gated: assert property (suspend_o |-> suspend_oe_o)
      else $error("suspend out while disabled");
   a_zlp_after_in: assert property (iso_zlp_o |-> $past(in_tok_i))
      else $error("zero length without token");
   a_hs_needs_ok: assert property ($rose(high_speed_active_o) |-> $past(hs_neg_ok_i && high_speed_allow_o))
      else $error("high speed without negotiation");
endmodule
bind usb_core_ctrl usb_core_ctrl_checker i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .host_mode_i,
   .soft_attach_avail_i, .tok_valid_i, .tok_addr_i, .in_tok_i, .hs_neg_ok_i, .addr_match_o, .target_addr_o,
   .line_drive_en_o, .high_speed_allow_o, .high_speed_active_o, .drive_reset_o, .suspend_o, .suspend_oe_o,
   .iso_zlp_o);
`default_nettype wire

/* verification/usb_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
module usb_bus_model (
   input wire logic clk_i,
   output logic [3:0] kind_o,
   output logic [6:0] tok_addr_o,
   output logic [3:0] in_ep_hit_o,
   output logic [2:0] line_o
);
   // ========
   // Idle bus
   initial begin
      kind_o = 4'h0;
      tok_addr_o = 7'h7F;
      in_ep_hit_o = 4'hF;
      line_o = 3'h0;
   end
   // ========
   // One token or chirp pulse: hs, in, sof, addr
   task automatic send(input logic [3:0] k, input logic [6:0] a, input logic [3:0] hit);
      @(posedge clk_i);
      kind_o <= k;
      tok_addr_o <= a;
      in_ep_hit_o <= hit;
      @(posedge clk_i);
      kind_o <= 4'h0;
      tok_addr_o <= ~a;
      in_ep_hit_o <= ~hit;
      #1;
   endtask
   // Reset, suspend, resume line levels
   task automatic lines(input logic [2:0] v);
      @(posedge clk_i);
      line_o <= v;
      repeat (4) @(posedge clk_i);
      #1;
   endtask
endmodule
`default_nettype wire

/* verification/usb_core_addr_power_epirq_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module usb_core_addr_power_epirq_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, host_mode_i = 1'b0, soft_attach_avail_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0, iso_ep_i = 4'h0, tx_packet_loaded_i = 4'h0, rx_done_i = 4'h0, wsel = 4'h1;
   logic [4:0] tx_done_i = 5'h00;
   logic [31:0] dat_i = 32'h0000_0000, dat_o, rdata;
   logic [3:0] kind, in_ep_hit_i, tx_send_ok_o;
   logic [2:0] line;
   wire logic tok_valid, sof_tok, in_tok, hs_ok, reset_line, suspend_line, resume_line;
   assign {hs_ok, in_tok, sof_tok, tok_valid} = kind;
   assign {reset_line, suspend_line, resume_line} = line;
   logic [6:0] tok_addr_i, target_addr_o;
   logic ack_o, addr_match_o, line_drive_en_o, high_speed_allow_o, high_speed_active_o, drive_reset_o;
   logic drive_resume_o, suspend_o, suspend_oe_o, iso_zlp_o, irq_o;
   int mismatches = 0, checked = 0, cycles = 0;
   always #25 clk_i = ~clk_i;
   usb_bus_model i_bus (.clk_i, .kind_o(kind), .tok_addr_o(tok_addr_i), .in_ep_hit_o(in_ep_hit_i), .line_o(line));
   usb_core_ctrl i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .host_mode_i, .soft_attach_avail_i, .tok_valid_i(tok_valid), .tok_addr_i, .sof_tok_i(sof_tok),
      .in_tok_i(in_tok), .in_ep_hit_i, .iso_ep_i, .tx_packet_loaded_i, .tx_done_i, .rx_done_i,
      .hs_neg_ok_i(hs_ok), .bus_reset_line_i(reset_line), .suspend_line_i(suspend_line),
      .resume_line_i(resume_line),
      .addr_match_o, .target_addr_o, .line_drive_en_o, .high_speed_allow_o, .high_speed_active_o,
      .drive_reset_o, .drive_resume_o, .suspend_o, .suspend_oe_o, .tx_send_ok_o, .iso_zlp_o, .irq_o);
   // ========
   // Tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= wsel;
      dat_i <= 32'(d);
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rdata = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check($sformatf("reg %h", a), rdata, 32'(e));
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic ev(input logic [4:0] tx, input logic [3:0] rx, input logic [3:0] ld);
      @(posedge clk_i);
      tx_done_i <= tx;
      rx_done_i <= rx;
      tx_packet_loaded_i <= ld;
      @(posedge clk_i);
      tx_done_i <= 5'h00;
      rx_done_i <= 4'h0;
      tx_packet_loaded_i <= 4'h0;
      #1;
   endtask
   task automatic complete_run;
      $display("Checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   // ========
   // Sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(1);
      check("hs allow", high_speed_allow_o, 1'b1);
      rd(usb_core_pkg::POWER_OFS, 8'h20);
      rd(usb_core_pkg::FUNC_ADDR_OFS, 8'h00);
      rd(8'hFC, 8'h00);
      bus(1'b1, usb_core_pkg::FUNC_ADDR_OFS, 8'hD5);
      rd(usb_core_pkg::FUNC_ADDR_OFS, 8'h55);
      check("target", target_addr_o, 7'h55);
      wsel = 4'h2;
      bus(1'b1, usb_core_pkg::FUNC_ADDR_OFS, 8'h7F);
      wsel = 4'h1;
      rd(usb_core_pkg::FUNC_ADDR_OFS, 8'h55);
      i_bus.send(4'h1, 7'h55, 4'h0);
      check("match", addr_match_o, 1'b1);
      i_bus.send(4'h1, 7'h54, 4'h0);
      check("miss", addr_match_o, 1'b0);
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'hFF);
      rd(usb_core_pkg::POWER_OFS, 8'hE5);
      check("drive on", line_drive_en_o, 1'b1);
      check("no resume", drive_resume_o, 1'b0);
      @(posedge clk_i) soft_attach_avail_i <= 1'b0;
      tick(1);
      check("no avail", line_drive_en_o, 1'b0);
      @(posedge clk_i) soft_attach_avail_i <= 1'b1;
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'h00);
      check("drive off", line_drive_en_o, 1'b0);
      i_bus.send(4'h8, 7'h00, 4'h0);
      check("full speed", high_speed_active_o, 1'b0);
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'h21);
      i_bus.send(4'h8, 7'h00, 4'h0);
      rd(usb_core_pkg::POWER_OFS, 8'h31);
      i_bus.lines(3'h4);
      rd(usb_core_pkg::POWER_OFS, 8'h29);
      i_bus.lines(3'h0);
      i_bus.lines(3'h2);
      rd(usb_core_pkg::POWER_OFS, 8'h23);
      check("suspend out", suspend_o, 1'b1);
      check("suspend oe", suspend_oe_o, 1'b1);
      rd(usb_core_pkg::COMMON_OFS, 8'h05);
      rd(usb_core_pkg::POWER_OFS, 8'h21);
      rd(usb_core_pkg::COMMON_OFS, 8'h00);
      i_bus.lines(3'h0);
      i_bus.lines(3'h2);
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'h25);
      tick(1);
      check("resume drive", drive_resume_o, 1'b1);
      rd(usb_core_pkg::POWER_OFS, 8'h25);
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'h20);
      tick(1);
      check("resume end", drive_resume_o, 1'b0);
      i_bus.lines(3'h0);
      @(posedge clk_i) host_mode_i <= 1'b1;
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'h28);
      tick(1);
      check("host reset", drive_reset_o, 1'b1);
      rd(usb_core_pkg::POWER_OFS, 8'h28);
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'h22);
      i_bus.lines(3'h2);
      i_bus.lines(3'h1);
      bus(1'b0, usb_core_pkg::POWER_OFS, 8'h00);
      check("resume auto", rdata[2], 1'b1);
      check("host resume", drive_resume_o, 1'b1);
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'h20);
      i_bus.lines(3'h0);
      @(posedge clk_i) host_mode_i <= 1'b0;
      ev(5'h1F, 4'hF, 4'h0);
      bus(1'b1, usb_core_pkg::TX_FLAGS_OFS, 8'h00);
      rd(usb_core_pkg::TX_FLAGS_OFS, 8'h1F);
      rd(usb_core_pkg::TX_FLAGS_OFS, 8'h00);
      rd(usb_core_pkg::RX_FLAGS_OFS, 8'h1E);
      rd(usb_core_pkg::RX_FLAGS_OFS, 8'h00);
      bus(1'b1, usb_core_pkg::IRQ_STAT_OFS, 8'h3F);
      rd(usb_core_pkg::IRQ_STAT_OFS, 8'h00);
      ev(5'h01, 4'h0, 4'h0);
      tick(2);
      check("irq masked", irq_o, 1'b0);
      bus(1'b1, usb_core_pkg::IRQ_MASK_OFS, 8'h01);
      tick(2);
      check("irq on", irq_o, 1'b1);
      bus(1'b1, usb_core_pkg::IRQ_STAT_OFS, 8'h01);
      tick(2);
      check("irq clear", irq_o, 1'b0);
      bus(1'b1, usb_core_pkg::POWER_OFS, 8'hA0);
      @(posedge clk_i) iso_ep_i <= 4'h1;
      ev(5'h00, 4'h0, 4'h1);
      i_bus.send(4'h4, 7'h00, 4'h1);
      check("zero length", iso_zlp_o, 1'b1);
      check("held", tx_send_ok_o, 4'h0);
      i_bus.send(4'h2, 7'h00, 4'h0);
      check("sof release", tx_send_ok_o, 4'h1);
      ev(5'h02, 4'h0, 4'h0);
      check("sent", tx_send_ok_o, 4'h0);
      complete_run();
   end
endmodule
`default_nettype wire
